// [src/cbm_bridge_regs.sv]
// Notes on behaviour
// [R1] Primary bus number is an 8-bit read/write register reset to zero.
// [R2] Secondary bus number is an 8-bit read/write register reset to zero.
// [R3] Subordinate bus number is an 8-bit read/write register reset to zero.
// [R4] Config cycles are forwarded by comparing against all three numbers.
// [R5] The 8-bit latency timer resets to zero and counts from frame start.
// [R6] After expiry the own transaction ends when the next data phase ends.
// [R7] Software should program the latency timer to at least 20h.
// [R8] Base registers 0 and 1 give each window's low address, reset zero.
// [R9] Base bits 31 to 12 are writable, giving 4 KB aligned windows.
// [R10] Base bits 11 to 0 read as zero and ignore writes.
// [R11] Windows steer PCI memory down and CardBus cycles up.
// [R12] Bridge control bits 8 and 9 mark windows 0 and 1 prefetchable.
// [R13] A window with zero base and zero limit claims nothing.
// [R14] Limit bits 31 to 12 are writable, 11 to 0 read zero, reset zero.
// [R15] Each limit register is the upper address of its window.
// [R16] An address hits from base up to limit with low bits all ones.
// [R17] The count clears at each new frame and value zero never expires.
`timescale 1ns/1ps
module cbm_bridge_regs
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire cbm_pkg::cbm_cfg_req_t cfg_req,
  output logic                      cfg_fwd_q,
  output logic                      cfg_type1_q,
  output logic                      cfg_local_q,
  input  wire cbm_pkg::cbm_mem_req_t pci_req,
  output logic                      mem_claim_q,
  output logic                      mem_pref_q,
  input  wire cbm_pkg::cbm_mem_req_t cb_req,
  output logic                      cb_up_q,
  input  wire logic                 cb_frame_start,
  input  wire logic                 cb_busy,
  input  wire logic                 cb_data_done,
  output logic                      lat_expired_q,
  output logic                      cb_stop_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cbm_pkg::cbm_state_t s_q;
  cbm_pkg::cbm_state_t s_d;

  logic [7:0] idx;
  logic       setup;
  logic       wr;
  logic [1:0] pci_hit;
  logic [1:0] cb_hit;

  assign idx   = paddr[9:2];
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite && s_q.pready;

  // ----------------------------------------------------------------
  // window compare
  // ----------------------------------------------------------------
  genvar w;
  generate
    for (w = 0; w < 2; w++)
    begin : g_win
      cbm_win_match u_pci
      (
        .base  (s_q.mb[w]),
        .limit (s_q.ml[w]),
        .addr  (pci_req.addr),
        .hit   (pci_hit[w])
      );
      cbm_win_match u_cb
      (
        .base  (s_q.mb[w]),
        .limit (s_q.ml[w]),
        .addr  (cb_req.addr),
        .hit   (cb_hit[w])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a window field; low twelve bits never stored
  function automatic logic [19:0] merge_win
  (
    input logic [19:0] old,
    input logic [31:0] wd,
    input logic [3:0]  st
  );
    logic [31:0] v;
    v = {old, 12'h000};
    for (int b = 1; b < 4; b++)
    begin
      if (st[b])
      begin
        v[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return v[31:cbm_pkg::WIN_LSB];
  endfunction

  function automatic logic mapped(input logic [7:0] i);
    case (i)
      cbm_pkg::IDX_PRI, cbm_pkg::IDX_SEC, cbm_pkg::IDX_SUB,
      cbm_pkg::IDX_LAT, cbm_pkg::IDX_MB0, cbm_pkg::IDX_ML0,
      cbm_pkg::IDX_MB1, cbm_pkg::IDX_ML1, cbm_pkg::IDX_BCTL,
      cbm_pkg::IDX_STAT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] rd;
    logic [7:0]  cnt_n;
    rd    = 32'h0000_0000;
    cnt_n = 8'(s_q.cnt + 8'h01);
    s_d   = s_q;

    // zero-wait slave: answer is prepared in the setup cycle
    s_d.pready  = setup;
    s_d.pslverr = setup && !mapped(idx);
    case (idx)
      cbm_pkg::IDX_PRI:  rd[7:0] = s_q.pri;                      // [R1]
      cbm_pkg::IDX_SEC:  rd[7:0] = s_q.sec;                      // [R2]
      cbm_pkg::IDX_SUB:  rd[7:0] = s_q.sub;                      // [R3]
      cbm_pkg::IDX_LAT:  rd[7:0] = s_q.lat;                      // [R5]
      cbm_pkg::IDX_MB0:  rd = {s_q.mb[0], 12'h000};         // [R8] [R10]
      cbm_pkg::IDX_MB1:  rd = {s_q.mb[1], 12'h000};         // [R8] [R10]
      cbm_pkg::IDX_ML0:  rd = {s_q.ml[0], 12'h000};              // [R14]
      cbm_pkg::IDX_ML1:  rd = {s_q.ml[1], 12'h000};              // [R14]
      cbm_pkg::IDX_BCTL:
      begin
        rd[cbm_pkg::BCTL_PF0] = s_q.pf[0];
        rd[cbm_pkg::BCTL_PF1] = s_q.pf[1];
      end
      cbm_pkg::IDX_STAT:
      begin
        rd[cbm_pkg::STAT_EXP] = (s_q.lst == cbm_pkg::LT_EXP);
        rd[cbm_pkg::STAT_RUN] = (s_q.lst == cbm_pkg::LT_RUN);
        rd[cbm_pkg::STAT_CNT +: 8] = s_q.cnt;
      end
      default: rd = 32'h0000_0000;
    endcase
    s_d.prdata = setup ? rd : s_q.prdata;

    // register writes take effect at the access edge
    if (wr && pstrb[0])
    begin
      case (idx)
        cbm_pkg::IDX_PRI: s_d.pri = pwdata[7:0];                 // [R1]
        cbm_pkg::IDX_SEC: s_d.sec = pwdata[7:0];                 // [R2]
        cbm_pkg::IDX_SUB: s_d.sub = pwdata[7:0];                 // [R3]
        cbm_pkg::IDX_LAT: s_d.lat = pwdata[7:0];                 // [R5]
        default: s_d.pri = s_d.pri;
      endcase
    end
    if (wr)
    begin
      case (idx)
        cbm_pkg::IDX_MB0:                                   // [R9] [R10]
          s_d.mb[0] = merge_win(s_q.mb[0], pwdata, pstrb);
        cbm_pkg::IDX_MB1:                                   // [R9] [R10]
          s_d.mb[1] = merge_win(s_q.mb[1], pwdata, pstrb);
        cbm_pkg::IDX_ML0:                                   // [R14]
          s_d.ml[0] = merge_win(s_q.ml[0], pwdata, pstrb);
        cbm_pkg::IDX_ML1:                                   // [R14]
          s_d.ml[1] = merge_win(s_q.ml[1], pwdata, pstrb);
        cbm_pkg::IDX_BCTL:
        begin
          if (pstrb[1])
          begin
            s_d.pf[0] = pwdata[cbm_pkg::BCTL_PF0];               // [R12]
            s_d.pf[1] = pwdata[cbm_pkg::BCTL_PF1];               // [R12]
          end
        end
        default: s_d.mb = s_d.mb;
      endcase
    end

    // configuration forwarding decision, one cycle after the request
    s_d.cfg_local = cfg_req.valid && (cfg_req.bus == s_q.pri);   // [R4]
    s_d.cfg_fwd   = cfg_req.valid && (cfg_req.bus != s_q.pri)
                    && (cfg_req.bus >= s_q.sec)
                    && (cfg_req.bus <= s_q.sub);                 // [R4]
    s_d.cfg_type1 = s_d.cfg_fwd && (cfg_req.bus != s_q.sec);     // [R4]

    // memory windows, down from PCI and up from CardBus
    s_d.mem_claim = pci_req.valid && (|pci_hit);       // [R11] [R13] [R16]
    s_d.mem_pref  = pci_req.valid
                    && (pci_hit[0] ? s_q.pf[0]
                                   : (pci_hit[1] && s_q.pf[1])); // [R12]
    // cycles outside both windows belong to the host side
    s_d.cb_up     = cb_req.valid && !(|cb_hit);                  // [R11]

    // latency timer; stop is a one-cycle pulse
    s_d.cb_stop = 1'b0;
    case (s_q.lst)
      cbm_pkg::LT_IDLE:
      begin
        s_d.lst = cbm_pkg::LT_IDLE;
      end
      cbm_pkg::LT_RUN:
      begin
        s_d.cnt = cnt_n;                                         // [R5]
        if (!cb_busy)
        begin
          s_d.lst = cbm_pkg::LT_IDLE;
        end
        else if ((s_q.lat != 8'h00) && (cnt_n == s_q.lat))      // [R17]
        begin
          s_d.lst = cbm_pkg::LT_EXP;
        end
      end
      cbm_pkg::LT_EXP:
      begin
        if (!cb_busy)
        begin
          s_d.lst = cbm_pkg::LT_IDLE;
        end
        else if (cb_data_done)
        begin
          s_d.cb_stop = 1'b1;                                    // [R6]
          s_d.lst     = cbm_pkg::LT_IDLE;
        end
      end
      default: s_d.lst = cbm_pkg::LT_IDLE;
    endcase
    // a new frame always restarts the count, whatever came before
    if (cb_frame_start)
    begin
      s_d.cnt = 8'h00;                                           // [R17]
      s_d.lst = cbm_pkg::LT_RUN;                                 // [R5]
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q           <= '0;
      s_q.pri       <= cbm_pkg::RST_BUS;
      s_q.sec       <= cbm_pkg::RST_BUS;
      s_q.sub       <= cbm_pkg::RST_BUS;
      s_q.lat       <= cbm_pkg::RST_LAT;
      s_q.mb        <= {cbm_pkg::RST_WIN, cbm_pkg::RST_WIN};
      s_q.ml        <= {cbm_pkg::RST_WIN, cbm_pkg::RST_WIN};
      s_q.pf        <= cbm_pkg::RST_PF;
      s_q.lst       <= cbm_pkg::LT_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata        = s_q.prdata;
  assign pready        = s_q.pready;
  assign pslverr       = s_q.pslverr;
  assign cfg_fwd_q     = s_q.cfg_fwd;
  assign cfg_type1_q   = s_q.cfg_type1;
  assign cfg_local_q   = s_q.cfg_local;
  assign mem_claim_q   = s_q.mem_claim;
  assign mem_pref_q    = s_q.mem_pref;
  assign cb_up_q       = s_q.cb_up;
  assign lat_expired_q = (s_q.lst == cbm_pkg::LT_EXP);
  assign cb_stop_q     = s_q.cb_stop;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_chk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_byte(logic [7:0] i);
    psel && penable && pwrite && pready && pstrb[0] && (idx == i);
  endsequence

  sequence s_rd_setup(logic [7:0] i);
    psel && !penable && !pwrite && (idx == i);
  endsequence

  property p_pri_write;
    logic [7:0] v;
    (s_wr_byte(cbm_pkg::IDX_PRI), v = pwdata[7:0])
      |=> (s_q.pri == v);
  endproperty
  a_pri_write: assert property (p_pri_write)                     // [R1]
    else $error("primary bus number did not read back");

  property p_sec_read;
    s_rd_setup(cbm_pkg::IDX_SEC) |=> pready && (prdata == {24'h0, s_q.sec});
  endproperty
  a_sec_read: assert property (p_sec_read)                      // [R2]
    else $error("secondary bus number read wrong");

  property p_cfg_fwd;
    (cfg_req.valid && (cfg_req.bus > s_q.sec) && (cfg_req.bus <= s_q.sub)
      && (cfg_req.bus != s_q.pri) && $stable(s_q.sec))
      |=> cfg_fwd_q && cfg_type1_q;
  endproperty
  a_cfg_fwd: assert property (p_cfg_fwd)                        // [R4]
    else $error("config cycle beneath the bridge not forwarded");

  property p_lat_start;
    cb_frame_start |=> (s_q.cnt == 8'h00) && (s_q.lst == cbm_pkg::LT_RUN);
  endproperty
  a_lat_start: assert property (p_lat_start)               // [R5] [R17]
    else $error("latency count not restarted at frame");

  sequence s_expired_done;
    lat_expired_q && cb_busy && cb_data_done && !cb_frame_start;
  endsequence

  property p_lat_stop;
    s_expired_done |=> cb_stop_q ##1 !cb_stop_q;
  endproperty
  a_lat_stop: assert property (p_lat_stop)                      // [R6]
    else $error("expired transaction not stopped after data phase");

  property p_lat_zero;
    (s_q.lat == 8'h00) && !lat_expired_q && $stable(s_q.lat)
      |=> !lat_expired_q;
  endproperty
  a_lat_zero: assert property (p_lat_zero)                      // [R17]
    else $error("zero latency value caused expiry");

  property p_base_low;
    s_rd_setup(cbm_pkg::IDX_MB0) |=> (prdata[11:0] == 12'h000);
  endproperty
  a_base_low: assert property (p_base_low)                      // [R10]
    else $error("memory base low bits not zero");

  property p_no_claim;
    (s_q.mb == '0) && (s_q.ml == '0) |=> !mem_claim_q;
  endproperty
  a_no_claim: assert property (p_no_claim)                      // [R13]
    else $error("closed windows claimed a transaction");

  property p_claim_w0;
    (pci_req.valid && (s_q.mb[0] != '0)
      && (pci_req.addr[31:12] >= s_q.mb[0])
      && (pci_req.addr[31:12] <= s_q.ml[0]))
      |=> mem_claim_q && (mem_pref_q == $past(s_q.pf[0]));
  endproperty
  a_claim_w0: assert property (p_claim_w0)           // [R11] [R12] [R16]
    else $error("window 0 hit not claimed as configured");

endmodule

// [src/cbm_pkg.sv]
package cbm_pkg;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PRI  = 8'h18;
  localparam logic [7:0] IDX_SEC  = 8'h19;
  localparam logic [7:0] IDX_SUB  = 8'h1A;
  localparam logic [7:0] IDX_LAT  = 8'h1B;
  localparam logic [7:0] IDX_MB0  = 8'h1C;
  localparam logic [7:0] IDX_ML0  = 8'h20;
  localparam logic [7:0] IDX_MB1  = 8'h24;
  localparam logic [7:0] IDX_ML1  = 8'h28;
  localparam logic [7:0] IDX_BCTL = 8'h40;
  localparam logic [7:0] IDX_STAT = 8'h41;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          WIN_LSB   = 12;
  localparam int          BCTL_PF0  = 8;
  localparam int          BCTL_PF1  = 9;
  localparam int          STAT_EXP  = 0;
  localparam int          STAT_RUN  = 1;
  localparam int          STAT_CNT  = 8;
  localparam logic [7:0]  RST_BUS   = 8'h00;
  localparam logic [7:0]  RST_LAT   = 8'h00;
  localparam logic [19:0] RST_WIN   = 20'h00000;
  localparam logic [1:0]  RST_PF    = 2'h0;
  localparam logic [7:0]  LAT_REC   = 8'h20;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    LT_IDLE = 3'b001,
    LT_RUN  = 3'b010,
    LT_EXP  = 3'b100
  } cbm_lat_st_t;

  typedef struct packed
  {
    logic       valid;
    logic [7:0] bus;
  } cbm_cfg_req_t;

  typedef struct packed
  {
    logic        valid;
    logic [31:0] addr;
  } cbm_mem_req_t;

  typedef struct packed
  {
    logic [7:0]       pri;
    logic [7:0]       sec;
    logic [7:0]       sub;
    logic [7:0]       lat;
    logic [1:0][19:0] mb;
    logic [1:0][19:0] ml;
    logic [1:0]       pf;
    cbm_lat_st_t      lst;
    logic [7:0]       cnt;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             cfg_fwd;
    logic             cfg_type1;
    logic             cfg_local;
    logic             mem_claim;
    logic             mem_pref;
    logic             cb_up;
    logic             cb_stop;
  } cbm_state_t;

endpackage

// [src/cbm_win_match.sv]
`timescale 1ns/1ps
module cbm_win_match
(
  input  wire logic [19:0] base,
  input  wire logic [19:0] limit,
  input  wire logic [31:0] addr,
  output logic             hit
);

  logic en;

  // all-zero window stays closed, so reset does not map page zero
  assign en  = (base != cbm_pkg::RST_WIN) || (limit != cbm_pkg::RST_WIN); // [R13]
  assign hit = en && (addr[31:cbm_pkg::WIN_LSB] >= base)        // [R16]
                  && (addr[31:cbm_pkg::WIN_LSB] <= limit);      // [R15]

endmodule

// [dv/cbm_cb_initiator.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// cardbus initiator stand-in: frame, busy level, data phases
// ----------------------------------------------------------------
module cbm_cb_initiator
#(
  parameter int DPHASE = 5,
  parameter int MAXPH  = 12
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic go,
  input  wire logic stop,
  output logic      frame_start,
  output logic      busy,
  output logic      data_done
);
  int cnt;
  int ph;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_start <= 1'b0;
      busy        <= 1'b0;
      data_done   <= 1'b0;
      cnt         <= 0;
      ph          <= 0;
    end
    else
    begin
      frame_start <= go;
      data_done   <= 1'b0;
      if (go)
      begin
        busy <= 1'b1;
        cnt  <= 0;
        ph   <= 0;
      end
      else if (busy)
      begin
        // terminate as soon as the bridge asks for it
        if (stop)
          busy <= 1'b0;
        else if (cnt == DPHASE - 1)
        begin
          cnt       <= 0;
          data_done <= 1'b1;
          ph        <= ph + 1;
          // a bounded burst so an unexpired timer still lets go
          if (ph == MAXPH - 1)
            busy <= 1'b0;
        end
        else
          cnt <= cnt + 1;
      end
    end
  end
endmodule

// [dv/cardbus_bridge_bus_numbers_mem_windows_test.sv]
`timescale 1ns/1ps
module cardbus_bridge_bus_numbers_mem_windows_test;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  cbm_pkg::cbm_cfg_req_t cfg_req;
  cbm_pkg::cbm_mem_req_t pci_req;
  cbm_pkg::cbm_mem_req_t cb_req;
  logic                  cfg_fwd_q;
  logic                  cfg_type1_q;
  logic                  cfg_local_q;
  logic                  mem_claim_q;
  logic                  mem_pref_q;
  logic                  cb_up_q;
  logic                  go;
  logic                  frame_start;
  logic                  busy;
  logic                  data_done;
  logic                  lat_expired_q;
  logic                  cb_stop_q;
  int                    errors;
  int                    num_checks;
  int                    cyc;

  cbm_bridge_regs u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_req(cfg_req), .cfg_fwd_q(cfg_fwd_q), .cfg_type1_q(cfg_type1_q),
    .cfg_local_q(cfg_local_q), .pci_req(pci_req),
    .mem_claim_q(mem_claim_q), .mem_pref_q(mem_pref_q), .cb_req(cb_req),
    .cb_up_q(cb_up_q), .cb_frame_start(frame_start), .cb_busy(busy),
    .cb_data_done(data_done), .lat_expired_q(lat_expired_q),
    .cb_stop_q(cb_stop_q)
  );

  cbm_cb_initiator u_card
  (
    .pclk(pclk), .presetn(presetn), .go(go), .stop(cb_stop_q),
    .frame_start(frame_start), .busy(busy), .data_done(data_done)
  );

  // ----------------------------------------------------------------
  // clock, timeout, reporting
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // apb master: holds the request until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count assumed; only the bench timeout ends this
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, ra(idx), d, rd, err);
  endtask

  task automatic cfg_chk(input logic [7:0] bus, input logic [2:0] exp);
    @(posedge pclk);
    cfg_req <= {1'b1, bus};
    @(posedge pclk);
    cfg_req.valid <= 1'b0;
    @(posedge pclk);
    check({cfg_fwd_q, cfg_type1_q, cfg_local_q}, exp);
  endtask

  task automatic mem_chk(input logic [31:0] a, input logic [2:0] exp);
    @(posedge pclk);
    pci_req <= {1'b1, a};
    cb_req  <= {1'b1, a};
    @(posedge pclk);
    pci_req.valid <= 1'b0;
    cb_req.valid  <= 1'b0;
    @(posedge pclk);
    check({mem_claim_q, mem_pref_q & mem_claim_q, cb_up_q}, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  logic [7:0]  idx_tab [10];
  logic [31:0] ones_tab[10];

  task automatic test_regs();
    logic [31:0] rd;
    logic        err;
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, ra(idx_tab[i]), 32'h0, rd, err);
      check(rd, 32'h0);
    end
    // untouched windows must not claim the bottom page
    mem_chk(32'h0000_0000, 3'b001);
    mem_chk(32'h0000_0FFF, 3'b001);
    for (int i = 0; i < 10; i++)
    begin
      wr(idx_tab[i], 32'hFFFF_FFFF);
      apb(1'b0, ra(idx_tab[i]), 32'h0, rd, err);
      check(rd, ones_tab[i]);
      check({31'h0, err}, 32'h0);
    end
    apb(1'b1, 12'h0B0, 32'hFFFF_FFFF, rd, err);
    apb(1'b0, 12'h0B0, 32'h0, rd, err);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test regs done");
  endtask

  task automatic test_cfg();
    wr(cbm_pkg::IDX_PRI, 32'h0000_0001);
    wr(cbm_pkg::IDX_SEC, 32'h0000_0002);
    wr(cbm_pkg::IDX_SUB, 32'h0000_0004);
    cfg_chk(8'h01, 3'b001);
    cfg_chk(8'h02, 3'b100);
    cfg_chk(8'h03, 3'b110);
    cfg_chk(8'h04, 3'b110);
    cfg_chk(8'h05, 3'b000);
    cfg_chk(8'h00, 3'b000);
    $display("test cfg done");
  endtask

  task automatic test_mem();
    wr(cbm_pkg::IDX_MB0, 32'h1000_0ABC);
    wr(cbm_pkg::IDX_ML0, 32'h1000_F000);
    wr(cbm_pkg::IDX_MB1, 32'h2000_0000);
    wr(cbm_pkg::IDX_ML1, 32'h2000_0000);
    wr(cbm_pkg::IDX_BCTL, 32'h0000_0200);
    mem_chk(32'h0FFF_FFFF, 3'b001);
    mem_chk(32'h1000_0000, 3'b100);
    mem_chk(32'h1000_FFFF, 3'b100);
    mem_chk(32'h1001_0000, 3'b001);
    mem_chk(32'h2000_0FFF, 3'b110);
    mem_chk(32'h2000_1000, 3'b001);
    $display("test mem done");
  endtask

  task automatic test_lat(input logic [7:0] lat);
    int n;
    int hits;
    logic pd;
    n = 0;
    hits = 0;
    wr(cbm_pkg::IDX_LAT, {24'h0, lat});
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (frame_start !== 1'b1 && n < 10);
    check({31'h0, frame_start}, 32'h1);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      if (lat_expired_q === 1'b1)
        hits++;
    end
    while (hits == 0 && n < 100);
    if (lat == 8'h00)
    begin
      check(hits, 0);
      $display("test latency zero done");
      return;
    end
    check(n, lat + 1);
    n = 0;
    do
    begin
      pd = data_done;
      @(posedge pclk);
      n++;
    end
    while (cb_stop_q !== 1'b1 && n < 20);
    check({cb_stop_q, pd}, 2'b11);
    @(posedge pclk);
    check({cb_stop_q, lat_expired_q}, 2'b00);
    $display("test latency done");
  endtask

  initial
  begin
    idx_tab  = '{cbm_pkg::IDX_PRI, cbm_pkg::IDX_SEC, cbm_pkg::IDX_SUB,
                 cbm_pkg::IDX_LAT, cbm_pkg::IDX_MB0, cbm_pkg::IDX_ML0,
                 cbm_pkg::IDX_MB1, cbm_pkg::IDX_ML1, cbm_pkg::IDX_BCTL,
                 cbm_pkg::IDX_STAT};
    ones_tab = '{32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFFFF_F000,
                 32'hFFFF_F000, 32'hFFFF_F000, 32'hFFFF_F000,
                 32'h0000_0300, 32'h0000_0000};
    errors = 0;
    num_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    cfg_req = '0;
    pci_req = '0;
    cb_req = '0;
    go = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_cfg();
    test_mem();
    // zero first: a cleared timer must never force termination
    test_lat(8'h00);
    // software keeps the timer at the advised floor
    test_lat(cbm_pkg::LAT_REC);
    tally_and_finish();
  end
endmodule
